//--- hdl/reset_pin_pkg.sv
// Operation
// - while hardware reset pin is low, hold all but real-time clock logic in reset
// - on hardware reset release, full reset of all but real-time clock logic
// - while soft reset pin is low, stay in software reset
// - on soft reset release, reset core, digital registers and peripherals
// - soft reset spares power-on-only registers, clock, debug and test state
// - once soft reset pin sensed low, drive it low as output
// - drive soft reset pin low exactly six system clock cycles, then sense
// - alternate sense and drive until the pin is sensed inactive
package reset_pin_pkg;

    localparam logic [2:0] DRIVE_CYCLES = 3'h6;
    localparam logic [2:0] COUNT_RESET = 3'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_DRIVE = 3'h2,
        ST_SENSE = 3'h4
    } seq_state_t;

    // reset outputs towards the rest of the chip, all active low
    typedef struct packed {
        logic porResetN;
        logic softResetN;
        logic keepResetN;
    } reset_out_t;

    typedef struct packed {
        seq_state_t state;
        logic [2:0] count;
        logic hwHeld;
        logic drivePin;
        reset_out_t resets;
    } seq_reg_t;

endpackage

//--- hdl/reset_pin_sequencer.sv
`timescale 1ns/100ps
module reset_pin_sequencer
    import reset_pin_pkg::*;
(
    // clock and power-up reset
    input wire logic clock,
    input wire logic rst_b,
    // hardware reset pin
    input wire logic hw_reset_n,
    // software reset pin, two-way
    input wire logic softResetPinIn,
    output logic softResetPinOut,
    output logic softResetPinOe,
    // reset outputs to the chip
    output logic porResetN,
    output logic softResetN,
    output logic rtcResetN
);

    seq_reg_t state_q;
    seq_reg_t state_d;
    logic hwSync;
    logic softSync;
    // phase decode, kept apart so the state logic reads like the rules
    logic hwActive;
    logic softLow;
    logic inDrive;
    logic inSense;
    logic driveDone;
    logic senseDone;

    reset_sync hwSyncInst (
        .clock(clock),
        .rst_b(rst_b),
        .pinIn(hw_reset_n),
        .pinSync(hwSync)
    );

    reset_sync softSyncInst (
        .clock(clock),
        .rst_b(rst_b),
        .pinIn(softResetPinIn),
        .pinSync(softSync)
    );

    assign hwActive = !hwSync;
    assign softLow = !softSync;
    assign inDrive = (state_q.state == ST_DRIVE);
    assign inSense = (state_q.state == ST_SENSE);

    // last of the six driven cycles
    assign driveDone = inDrive && (state_q.count == DRIVE_CYCLES - 3'h1);

    // sync latency flushed, so the level reflects the released line
    assign senseDone = inSense && (state_q.count == 3'(SYNC_STAGES));

    always_comb begin
        state_d = state_q;
        // por only lifts two edges after the pin is seen high again
        state_d.hwHeld = hwActive;
        state_d.resets.porResetN = !hwActive && !state_q.hwHeld;
        state_d.resets.keepResetN = 1'b1;
        if (hwActive) begin
            state_d.state = ST_RUN;
            state_d.count = COUNT_RESET;
            state_d.drivePin = 1'b0;
            state_d.resets.softResetN = 1'b0;
        end else begin
            unique case (state_q.state)
                ST_RUN: begin
                    // soft reset follows por out of a full reset
                    state_d.count = COUNT_RESET;
                    state_d.drivePin = 1'b0;
                    state_d.resets.softResetN = state_q.resets.porResetN;
                    if (softLow && !state_q.hwHeld) begin
                        state_d.state = ST_DRIVE;
                        state_d.drivePin = 1'b1;
                        state_d.resets.softResetN = 1'b0;
                    end
                end
                ST_DRIVE: begin
                    state_d.resets.softResetN = 1'b0;
                    state_d.drivePin = 1'b1;
                    state_d.count = state_q.count + 3'h1;
                    if (driveDone) begin
                        state_d.state = ST_SENSE;
                        state_d.drivePin = 1'b0;
                        state_d.count = COUNT_RESET;
                    end
                end
                ST_SENSE: begin
                    // still in soft reset while sensing
                    state_d.resets.softResetN = 1'b0;
                    state_d.drivePin = 1'b0;
                    state_d.count = state_q.count + 3'h1;
                    if (senseDone) begin
                        state_d.count = COUNT_RESET;
                        if (softLow) begin
                            state_d.state = ST_DRIVE;
                            state_d.drivePin = 1'b1;
                        end else begin
                            state_d.state = ST_RUN;
                            state_d.resets.softResetN = 1'b1;
                        end
                    end
                end
                default: begin
                    // illegal code: back to idle, soft reset kept on
                    state_d.state = ST_RUN;
                    state_d.count = COUNT_RESET;
                    state_d.drivePin = 1'b0;
                    state_d.resets.softResetN = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '{state: ST_RUN, count: COUNT_RESET, hwHeld: 1'b1,
                drivePin: 1'b0,
                resets: '{porResetN: 1'b0, softResetN: 1'b0,
                    keepResetN: 1'b0}};
        end else begin
            state_q <= state_d;
        end
    end

    assign softResetPinOut = 1'b0;
    assign softResetPinOe = state_q.drivePin;
    assign porResetN = state_q.resets.porResetN;
    assign softResetN = state_q.resets.softResetN;
    // rtc domain only cleared at power-up
    assign rtcResetN = state_q.resets.keepResetN;

endmodule

//--- hdl/reset_sync.sv
`timescale 1ns/100ps
module reset_sync
    import reset_pin_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // raw pin and synchronised level
    input wire logic pinIn,
    output logic pinSync
);

    logic [SYNC_STAGES-1:0] stage_q;

    // pins idle high through their pullups
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage_q <= '1;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], pinIn};
        end
    end

    assign pinSync = stage_q[SYNC_STAGES-1];

endmodule

//--- test/ext_reset_src.sv
`timescale 1ns/100ps
module ext_reset_src(
    input wire logic extLow,
    input wire logic oe,
    input wire logic drv,
    output logic pin
);
    // pulled-up line, low while either side pulls
    assign pin = !extLow && !(oe && !drv);
endmodule

//--- test/reset_pin_sequencer_sva.sv
`timescale 1ns/100ps
module reset_pin_sequencer_sva(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hw_reset_n,
    input wire logic softResetPinIn,
    input wire logic softResetPinOut,
    input wire logic softResetPinOe,
    input wire logic porResetN,
    input wire logic softResetN,
    input wire logic rtcResetN
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_hold; !hw_reset_n[*4] |=> !porResetN && !softResetN; endproperty
    a_hold: assert property (p_hold) else $error("hw hold");
    property p_rel; hw_reset_n[*5] |=> porResetN; endproperty
    a_rel: assert property (p_rel) else $error("hw release");
    property p_in; softResetPinOe |-> !softResetN; endproperty
    a_in: assert property (p_in) else $error("soft hold");
    property p_done; $fell(softResetPinOe) ##0
        (softResetPinIn && porResetN)[*3] |=> softResetN; endproperty
    a_done: assert property (p_done) else $error("soft done");
    property p_keep; $past(rst_b) |-> rtcResetN; endproperty
    a_keep: assert property (p_keep) else $error("rtc hit");
    // a hardware reset legally cuts the pin sequence short
    property p_drv; disable iff (!rst_b || !porResetN)
        softResetN && hw_reset_n && !softResetPinIn
        |-> ##4 softResetPinOe && !softResetPinOut; endproperty
    a_drv: assert property (p_drv) else $error("no drive");
    property p_six; disable iff (!rst_b || !porResetN)
        $rose(softResetPinOe)
        |-> softResetPinOe[*6] ##1 !softResetPinOe; endproperty
    a_six: assert property (p_six) else $error("drive len");
    property p_again; disable iff (!rst_b || !porResetN)
        $fell(softResetPinOe) ##0 !softResetPinIn[*3]
        |=> softResetPinOe; endproperty
    a_again: assert property (p_again) else $error("no repeat");
    c_hw: cover property (!hw_reset_n);
    c_rpt: cover property ($fell(softResetPinOe) ##3 $rose(softResetPinOe));
    c_end: cover property ($rose(softResetN));
endmodule
bind reset_pin_sequencer reset_pin_sequencer_sva u_sva(.clock, .rst_b,
    .hw_reset_n, .softResetPinIn, .softResetPinOut, .softResetPinOe,
    .porResetN, .softResetN, .rtcResetN);

//--- test/reset_pin_sequencer_tb_top.sv
`timescale 1ns/100ps
module reset_pin_sequencer_tb_top;
    logic clock = 0, rst_b = 0, hwN = 1, extLow = 0, pin, out, oe;
    logic porN, softN, rtcN;
    logic [7:0] oeCyc = 8'h0;
    logic [7:0] oeBase;
    int errCount, nChecks, cyc, n, seed = 32'h6D7F5184;
    always #25 clock = !clock;
    ext_reset_src far(.extLow, .oe, .drv(out), .pin);
    reset_pin_sequencer dut(.clock, .rst_b, .hw_reset_n(hwN),
        .softResetPinIn(pin), .softResetPinOut(out), .softResetPinOe(oe),
        .porResetN(porN), .softResetN(softN), .rtcResetN(rtcN));
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s exp %0d got %0d", nm, exp, got);
        end
    endtask
    task summarize;
        if (errCount == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        oeCyc <= oeCyc + 8'(oe === 1'b1);
        if (cyc == 2000) begin
            errCount++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1;
        repeat (6) @(negedge clock);
        hwN = 0;
        repeat (8) @(negedge clock);
        chk("por", 0, porN);
        chk("rtc", 1, rtcN);
        hwN = 1;
        repeat (7) @(negedge clock);
        chk("por", 1, porN);
        chk("soft", 1, softN);
        for (int i = 0; i < 4; i++) begin
            n = $unsigned($random(seed)) % 3 + 1;
            oeBase = oeCyc;
            extLow = 1;
            for (int p = 1; p <= n; p++) begin
                while (oe !== 1'b1) @(negedge clock);
                chk("soft", 0, softN);
                chk("pinOut", 0, out);
                // hold on earlier passes; on the last pass let go mid-drive so the next sense sees it high
                repeat (3) @(negedge clock);
                extLow = (p < n);
                while (oe === 1'b1) @(negedge clock);
            end
            repeat (8) @(negedge clock);
            chk("drive", 8'(6 * n), 8'(oeCyc - oeBase));
            chk("soft", 1, softN);
        end
        // hardware reset cuts a soft sequence short
        extLow = 1;
        while (oe !== 1'b1) @(negedge clock);
        hwN = 0;
        extLow = 0;
        repeat (4) @(negedge clock);
        chk("abort", 0, oe);
        chk("por", 0, porN);
        hwN = 1;
        repeat (8) @(negedge clock);
        chk("soft", 1, softN);
        chk("rtc", 1, rtcN);
        summarize();
    end
endmodule
